// ==== hw/sadd_params.svh ====
// constants for the signed add datapath
`ifndef SADD_PARAMS_SVH
`define SADD_PARAMS_SVH
`define OPC_HI        31
`define OPC_LO        26
`define EFF_HI        25
`define EFF_LO        22
`define COND_HI       21
`define COND_LO       18
`define DST_HI        17
`define DST_LO        9
`define SRC_HI        8
`define SRC_LO        0
`define EFF_Z_BIT     3
`define EFF_C_BIT     2
`define EFF_R_BIT     1
`define EFF_I_BIT     0
`define SIGNED_ADD_OP 6'h22
`define REG_COUNT     512
`define WORD_ZERO     32'h00000000
`define WB_ADDR_OPCODE_FIELD 32'h00000000
`define WB_ADDR_STAT  32'h00000004
`define WB_ADDR_REGS  32'h00000800
`define WB_REG_IDX_HI 10
`define WB_REG_IDX_LO 2
`define STAT_Z_BIT    0
`define STAT_C_BIT    1
`define STAT_BUSY_BIT 2
`define WB_ADDR_REGS_END 32'h00001000
`define SIGN_BIT      31
`endif

// ==== hw/sadd_pkg.sv ====
// types for the signed add datapath
package sadd_pkg;
  typedef struct packed {
    logic [5:0] opcodeField;
    logic       zeroFlagWriteSel;
    logic       carryFlagWriteSel;
    logic       resultWriteSel;
    logic       immSel;
    logic [3:0] execConditionField;
    logic [8:0] dstRegField;
    logic [8:0] srcOperandField;
  } opcode_field_t;
  typedef struct packed {
    logic [31:0] sum;
    logic        zero;
    logic        ovf;
  } add_res_t;
  typedef enum logic [1:0] {IDLE, EXEC, ACK} state_t;
endpackage

// ==== hw/signed_adder.sv ====
// combinational signed adder with zero and signed overflow outputs
`include "sadd_params.svh"

module signed_adder (
  input  wire logic [31:0]      opA,
  input  wire logic [31:0]      opB,
  output sadd_pkg::add_res_t    res
);
  import sadd_pkg::*;
  logic [31:0] s;
  always_comb begin
    s        = opA + opB;
    res.sum  = s;
    res.zero = (s == `WORD_ZERO);
    // same-sign operands giving other-sign sum: past max or below min
    res.ovf  = (opA[`SIGN_BIT] == opB[`SIGN_BIT]) && (s[`SIGN_BIT] != opA[`SIGN_BIT]);
  end
endmodule

// ==== hw/signed_add_datapath.sv ====
// signed add execution datapath with register file and wishbone slave
`include "sadd_params.svh"

// Overview of operation
// - with zero update, zero flag set when sum is zero, else cleared
// - with carry update, carry set when sum passes max positive value
// - carry also set below most negative; exact most negative clears it
// - destination field addresses the register giving first operand
// - source field addresses a register unless immediate bit selects literal
// - result, zero and carry are each written only when selected
// - fields: opcode 31:26, effects 25:22, condition 21:18, dst 17:9, src 8:0
// - flag update selections clear by default, flags then unchanged
module signed_add_datapath (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             zeroFlag,
  output logic             carryFlag
);
  import sadd_pkg::*;

  logic [31:0] regFile_q [`REG_COUNT];
  logic [31:0] regWrData;
  logic [8:0]  regWrIdx;
  logic        regWrEn;
  opcode_field_t      opcode_field_q, opcode_field_d;
  logic        z_q, z_d, c_q, c_d;
  state_t      st_q, st_d;
  logic        ack_q, ack_d;
  logic [31:0] rd_q, rd_d;
  logic [31:0] opA, opB;
  add_res_t    res;
  logic        req;
  logic [31:0] merged;
  logic [31:0] curWord;

  // a request is not taken again while its ack stands, so a slow master is served once
  assign req = wb_cyc_i && wb_stb_i && !ack_q;

  always_comb begin
    opA = regFile_q[opcode_field_q.dstRegField];
    opB = opcode_field_q.immSel ? {23'h000000, opcode_field_q.srcOperandField}
                         : regFile_q[opcode_field_q.srcOperandField];
  end

  signed_adder u_add (
    .opA (opA),
    .opB (opB),
    .res (res)
  );

  // byte lanes that are not enabled keep the word already stored
  assign curWord = regFile_q[wb_adr_i[`WB_REG_IDX_HI:`WB_REG_IDX_LO]];
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign merged[b*8 +: 8] = wb_sel_i[b] ? wb_dat_i[b*8 +: 8] : curWord[b*8 +: 8];
  end

  // bus write and execute share the array; execute owns it in EXEC
  always_comb begin
    st_d      = st_q;
    opcode_field_d   = opcode_field_q;
    z_d       = z_q;
    c_d       = c_q;
    ack_d     = 1'b0;
    rd_d      = rd_q;
    regWrEn   = 1'b0;
    regWrIdx  = opcode_field_q.dstRegField;
    regWrData = res.sum;
    case (st_q)
      IDLE: begin
        if (req) begin
          ack_d = 1'b1;
          rd_d  = `WORD_ZERO;
          if (wb_adr_i == `WB_ADDR_OPCODE_FIELD) begin
            if (wb_we_i) begin
              opcode_field_d = opcode_field_t'(wb_dat_i);
              st_d    = EXEC;
              ack_d   = 1'b0;
            end else begin
              rd_d = opcode_field_q;
            end
          end else if (wb_adr_i == `WB_ADDR_STAT) begin
            rd_d[`STAT_Z_BIT] = z_q;
            rd_d[`STAT_C_BIT] = c_q;
          end else if (wb_adr_i >= `WB_ADDR_REGS
                       && wb_adr_i < `WB_ADDR_REGS_END) begin
            regWrIdx = wb_adr_i[`WB_REG_IDX_HI:`WB_REG_IDX_LO];
            if (wb_we_i) begin
              regWrEn   = 1'b1;
              regWrData = merged;
            end else begin
              rd_d = regFile_q[regWrIdx];
            end
          end
          st_d = (st_d == EXEC) ? EXEC : ACK;
        end
      end
      EXEC: begin
        if (opcode_field_q.opcodeField == `SIGNED_ADD_OP) begin
          regWrEn = opcode_field_q.resultWriteSel;
          if (opcode_field_q.zeroFlagWriteSel) z_d = res.zero;
          if (opcode_field_q.carryFlagWriteSel) c_d = res.ovf;
        end
        ack_d = 1'b1;
        rd_d  = `WORD_ZERO;
        st_d  = ACK;
      end
      ACK: begin
        st_d = IDLE;
      end
      default: st_d = IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q    <= IDLE;
      opcode_field_q <= opcode_field_t'(`WORD_ZERO);
      z_q     <= 1'b0;
      c_q     <= 1'b0;
      ack_q   <= 1'b0;
      rd_q    <= `WORD_ZERO;
    end else begin
      st_q    <= st_d;
      opcode_field_q <= opcode_field_d;
      z_q     <= z_d;
      c_q     <= c_d;
      ack_q   <= ack_d;
      rd_q    <= rd_d;
    end
  end

  // storage has no reset; software loads operands before use
  always_ff @(posedge mclk) begin
    if (regWrEn) begin
      regFile_q[regWrIdx] <= regWrData;
    end
  end

  assign wb_ack_o  = ack_q;
  assign wb_dat_o  = rd_q;
  assign zeroFlag  = z_q;
  assign carryFlag = c_q;

  a_zero_update: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == EXEC && opcode_field_q.opcodeField == `SIGNED_ADD_OP && opcode_field_q.zeroFlagWriteSel)
    |=> (z_q == ($past(res.sum) == `WORD_ZERO)))
    else $error("zero flag does not match sum");
  a_carry_ovf: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == EXEC && opcode_field_q.opcodeField == `SIGNED_ADD_OP && opcode_field_q.carryFlagWriteSel
     && !opA[31] && !opB[31]) |=> (c_q == $past(res.sum[31])))
    else $error("carry wrong on positive overflow");
  a_carry_neg: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == EXEC && opcode_field_q.opcodeField == `SIGNED_ADD_OP && opcode_field_q.carryFlagWriteSel
     && opA[31] && opB[31]) |=> (c_q == !$past(res.sum[31])))
    else $error("carry wrong on negative overflow");
  a_flags_hold: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == EXEC && !opcode_field_q.zeroFlagWriteSel && !opcode_field_q.carryFlagWriteSel)
    |=> $stable(z_q) && $stable(c_q))
    else $error("flags changed without selection");
  a_result_write: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == EXEC) |-> (regWrEn == (opcode_field_q.opcodeField == `SIGNED_ADD_OP
                                    && opcode_field_q.resultWriteSel)))
    else $error("result write enable wrong");
  a_sum_wrap: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == EXEC && regWrEn) |-> (regWrData == opA + opB))
    else $error("stored sum not wrapped add");
  a_imm_operand: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == EXEC && opcode_field_q.immSel) |-> (opB == {23'h000000, opcode_field_q.srcOperandField}))
    else $error("immediate operand wrong");
  a_dst_operand: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == EXEC && regWrEn) |-> (regWrIdx == opcode_field_q.dstRegField))
    else $error("destination index wrong");
  a_ack_timing: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == IDLE && req && wb_we_i && wb_adr_i == `WB_ADDR_OPCODE_FIELD) |=> ##1 wb_ack_o)
    else $error("instruction write not acked in two cycles");
  a_zero_hold: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == EXEC && !opcode_field_q.zeroFlagWriteSel) |=> $stable(z_q))
    else $error("zero flag changed without selection");
  a_carry_hold: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == EXEC && !opcode_field_q.carryFlagWriteSel) |=> $stable(c_q))
    else $error("carry flag changed without selection");
  a_carry_mixed: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == EXEC && opcode_field_q.opcodeField == `SIGNED_ADD_OP && opcode_field_q.carryFlagWriteSel
     && (opA[`SIGN_BIT] != opB[`SIGN_BIT])) |=> !c_q)
    else $error("carry set on mixed-sign add");
  a_zero_clear: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == EXEC && opcode_field_q.opcodeField == `SIGNED_ADD_OP && opcode_field_q.zeroFlagWriteSel
     && (opA + opB != `WORD_ZERO)) |=> !z_q)
    else $error("zero flag set on non-zero sum");
  a_nonadd_noop: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == EXEC && opcode_field_q.opcodeField != `SIGNED_ADD_OP) |=> $stable(z_q) && $stable(c_q))
    else $error("flags changed by other opcode");

  // bus handshake timing and address decode
  a_plain_ack: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == IDLE && req && !(wb_we_i && wb_adr_i == `WB_ADDR_OPCODE_FIELD)) |=> wb_ack_o)
    else $error("plain access not acked in one cycle");
  a_ack_pulse: assert property (@(posedge mclk) disable iff (!rstn)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_exec_ack: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == EXEC) |=> (wb_ack_o && st_q == ACK))
    else $error("execute cycle not followed by ack");
  a_unmapped_write: assert property (@(posedge mclk) disable iff (!rstn)
    (st_q == IDLE && req && wb_adr_i != `WB_ADDR_OPCODE_FIELD && wb_adr_i < `WB_ADDR_REGS)
    |-> !regWrEn)
    else $error("unmapped write reached the array");

  c_zero_set: cover property (@(posedge mclk) disable iff (!rstn)
    st_q == EXEC && opcode_field_q.zeroFlagWriteSel && res.zero);
  c_ovf: cover property (@(posedge mclk) disable iff (!rstn)
    st_q == EXEC && opcode_field_q.carryFlagWriteSel && res.ovf);
  c_imm: cover property (@(posedge mclk) disable iff (!rstn)
    st_q == EXEC && opcode_field_q.immSel && opcode_field_q.resultWriteSel);
  c_carry_neg: cover property (@(posedge mclk) disable iff (!rstn)
    st_q == EXEC && opcode_field_q.carryFlagWriteSel && res.ovf && opA[`SIGN_BIT]);
  c_nonadd: cover property (@(posedge mclk) disable iff (!rstn)
    st_q == EXEC && opcode_field_q.opcodeField != `SIGNED_ADD_OP);
endmodule

// ==== bench/test_signed_add_datapath.sv ====
// self-checking bench for the signed add datapath
module test_signed_add_datapath;
  timeunit 1ns;
  timeprecision 1ps;
  import sadd_pkg::*;
  logic        mclk, rstn, cyc, stb, we, ack, zf, cf, zq, cq;
  logic [31:0] adr, dati, dato, rd;
  logic [3:0]  sel;
  int          err_count, cmp_count, cycN, seed, i;
  opcode_field_t      ins;
  logic [31:0] ta [8] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h1, 32'h1,
                          32'h7FFFFFFE, 32'h7FFFFFFE, 32'h80000001, 32'h80000001};
  logic [31:0] tb [8] = '{32'h1, 32'h2, 32'hFFFFFFFF, 32'hFFFFFFFE,
                          32'h1, 32'h2, 32'hFFFFFFFF, 32'hFFFFFFFE};

  signed_add_datapath i_signed_add_datapath (
    .mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dati), .wb_dat_o(dato),
    .wb_ack_o(ack), .zeroFlag(zf), .carryFlag(cf));

  initial begin
    mclk = 0;
    forever #4 mclk = ~mclk;
  end

  // whole run is a few thousand cycles; the ceiling only catches a hung handshake
  always @(posedge mclk) begin
    cycN++;
    if (cycN == 40000) begin
      err_count++;
      report_and_stop();
    end
  end

  task report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // one classic cycle; request held until ack is seen at a rising edge
  task wbx(input logic w, input logic [31:0] ad, dt, output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    dati <= dt;
    do @(posedge mclk); while (ack !== 1'b1);
    r = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask

  task chkWord(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: word %h expected %h", $time, g, e);
    end
  endtask

  task chkFlags(input logic [1:0] g, e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: carry/zero %b expected %b", $time, g, e);
    end
  endtask

  // expected {overflow, sum}: the exact sum is held against the signed 32-bit range
  function automatic logic [32:0] addExp(input logic [31:0] a, b);
    longint t;
    t = longint'($signed(a)) + longint'($signed(b));
    return {(t > 64'sh000000007FFFFFFF) || (t < 64'shFFFFFFFF80000000), t[31:0]};
  endfunction

  // eff is {zero write, carry write, result write, immediate}
  task runAdd(input logic [31:0] a, b, input logic [3:0] eff, input logic [5:0] opc);
    logic [8:0]  d;
    logic [31:0] bb;
    logic [32:0] ex;
    logic        isAdd;
    d = 9'($random(seed));
    bb = eff[0] ? {23'h0, b[8:0]} : b;
    ex = addExp(a, bb);
    isAdd = (opc == 6'h22);
    wbx(1'b1, 32'h800 + {21'h0, d, 2'b00}, a, rd);
    wbx(1'b1, 32'h800 + {21'h0, ~d, 2'b00}, b, rd);
    ins = '{opc, eff[3], eff[2], eff[1], eff[0], 4'hF, d, eff[0] ? b[8:0] : ~d};
    wbx(1'b1, 32'h0, ins, rd);
    if (isAdd && eff[3]) zq = (ex[31:0] == 32'h0);
    if (isAdd && eff[2]) cq = ex[32];
    wbx(1'b0, 32'h4, 32'h0, rd);
    chkFlags(rd[1:0], {cq, zq});
    chkFlags({cf, zf}, {cq, zq});
    wbx(1'b0, 32'h800 + {21'h0, d, 2'b00}, 32'h0, rd);
    chkWord(rd, (isAdd && eff[1]) ? ex[31:0] : a);
  endtask

  initial begin
    seed = 18753;
    {cyc, stb, we, adr, dati, zq, cq} = '0;
    sel = 4'hF;
    rstn = 1'b0;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    chkFlags({cf, zf}, 2'b00);
    for (i = 0; i < 8; i++) runAdd(ta[i], tb[i], 4'b1110, 6'h22);
    for (i = 0; i < 16; i++) runAdd(32'h7FFFFFFF, 32'h7FFFFFFF - i, 4'(i), 6'h22);
    for (i = 0; i < 16; i++) runAdd(32'h0, 32'h0, 4'(i), 6'h22);
    for (i = 0; i < 150; i++)
      runAdd($random(seed), $random(seed), 4'($random(seed)),
             ($random(seed) & 1) ? 6'h22 : 6'($random(seed)));
    wbx(1'b0, 32'h0, 32'h0, rd);
    chkWord(rd, ins);
    wbx(1'b0, 32'h100, 32'h0, rd);
    chkWord(rd, 32'h0);
    runAdd(32'h7FFFFFFE, 32'h2, 4'b1110, 6'h22);
    // only the enabled byte lanes of an array write land
    wbx(1'b1, 32'h800, 32'h11223344, rd);
    sel <= 4'h5;
    wbx(1'b1, 32'h800, 32'hAABBCCDD, rd);
    sel <= 4'hF;
    wbx(1'b0, 32'h800, 32'h0, rd);
    chkWord(rd, 32'h11BB33DD);
    // mid-run reset: flags and instruction word clear, the array keeps its words
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    {zq, cq} = 2'b00;
    @(posedge mclk);
    chkFlags({cf, zf}, {cq, zq});
    wbx(1'b0, 32'h0, 32'h0, rd);
    chkWord(rd, 32'h0);
    wbx(1'b0, 32'h800, 32'h0, rd);
    chkWord(rd, 32'h11BB33DD);
    runAdd(32'h80000001, 32'hFFFFFFFE, 4'b1110, 6'h22);
    report_and_stop();
  end
endmodule
